// *** common/hkd_pkg.sv ***
// shared constants for the housekeeping forwarding command decoder
// assumes one 125 MHz clock and a byte-wide command stream on that clock
package hkd_pkg;
    // clock and collection period
    localparam int unsigned CLK_PERIOD_PS = 8000;
    localparam longint unsigned HK_PERIOD_MS = 64'd11300;
    localparam longint unsigned HK_PERIOD_CYC_L = (HK_PERIOD_MS * 64'd1000000000) / CLK_PERIOD_PS;
    localparam int unsigned HK_PERIOD_CYC = int'(HK_PERIOD_CYC_L);

    // command layout, byte positions from the start of the packet
    localparam logic [3:0] POS_ID_HI = 4'h0;
    localparam logic [3:0] POS_ID_LO = 4'h1;
    localparam logic [3:0] POS_SEQ_HI = 4'h2;
    localparam logic [3:0] POS_SEQ_LO = 4'h3;
    localparam logic [3:0] POS_LEN_HI = 4'h4;
    localparam logic [3:0] POS_LEN_LO = 4'h5;
    localparam logic [3:0] POS_SVC_HDR = 4'h6;
    localparam logic [3:0] POS_SVC_TYPE = 4'h7;
    localparam logic [3:0] POS_SUBTYPE = 4'h8;
    localparam logic [3:0] POS_PAD = 4'h9;
    localparam logic [3:0] POS_PAD_PARAM = 4'ha;
    localparam logic [3:0] POS_SELECTOR = 4'hb;
    localparam logic [3:0] POS_LAST = 4'hd;

    // expected values of the fixed fields
    localparam logic [2:0] VERSION_VAL = 3'h0;
    localparam logic TYPE_VAL = 1'b1;
    localparam logic DFH_VAL = 1'b1;
    localparam logic [6:0] APID_VAL = 7'h47;
    localparam logic [3:0] CATEGORY_VAL = 4'hc;
    localparam logic [1:0] SEQ_FLAGS_VAL = 2'h3;
    localparam logic [2:0] SOURCE_GROUND = 3'h0;
    localparam logic [15:0] LENGTH_VAL = 16'h0007;
    localparam logic [2:0] SVC_VERSION_VAL = 3'h0;
    localparam logic CHECKSUM_FLAG_VAL = 1'b1;
    localparam logic [3:0] ACK_VAL = 4'h1;
    localparam logic [7:0] SVC_TYPE_VAL = 8'hc0;
    localparam logic [7:0] SUB_ENABLE_VAL = 8'h05;
    localparam logic [7:0] SUB_DISABLE_VAL = 8'h06;
    localparam logic [7:0] PAD_VAL = 8'h00;
    localparam logic [7:0] PAD_PARAM_VAL = 8'h01;
    localparam logic [7:0] SELECTOR_VAL = 8'h01;

    // error control word: crc-16 ccitt, msb first, residue zero over the whole packet
    localparam logic [15:0] CRC_POLY = 16'h1021;
    localparam logic [15:0] CRC_INIT = 16'hffff;
    localparam logic [15:0] CRC_RESIDUE = 16'h0000;

    // reset values
    localparam logic FWD_EN_RST = 1'b1;

    // reject reasons
    typedef enum logic [2:0] {
        HKD_RSN_NONE = 3'b000,
        HKD_RSN_FIELD = 3'b001,
        HKD_RSN_FOREIGN = 3'b010,
        HKD_RSN_LENGTH = 3'b011,
        HKD_RSN_CRC = 3'b100
    } hkd_reason_t;
endpackage : hkd_pkg

// *** common/hkd_crc_if.sv ***
// carries the command bytes to the error control checker and its running value
// assumes one clock shared by both ends
`timescale 1ns/10ps
interface hkd_crc_if;
    logic clear;
    logic valid;
    logic [7:0] data;
    logic [15:0] crc;
    modport feeder (output clear, output valid, output data, input crc);
    modport checker_end (input clear, input valid, input data, output crc);
endinterface : hkd_crc_if

// *** hdl/hkd_crc16.sv ***
// byte-serial crc-16 over the command stream
// assumes clear and valid arrive on the same clock as the byte
`timescale 1ns/10ps
module hkd_crc16 (
    input wire logic core_clk, // clock
    input wire logic rst_n, // async reset
    hkd_crc_if.checker_end crc_bus // byte in, crc out
);
    import hkd_pkg::*;

    logic [15:0] crc_q;
    logic [15:0] crc_d;

    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            if (r[15] ^ b[i]) begin
                r = {r[14:0], 1'b0} ^ CRC_POLY;
            end else begin
                r = {r[14:0], 1'b0};
            end
        end
        return r;
    endfunction : crc_step

    always_comb begin
        crc_d = crc_q;
        if (crc_bus.valid) begin
            crc_d = crc_step(crc_bus.clear ? CRC_INIT : crc_q, crc_bus.data);
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            crc_q <= CRC_INIT;
        end else begin
            crc_q <= crc_d;
        end
    end

    assign crc_bus.crc = crc_q;
endmodule : hkd_crc16

// *** hdl/hkd_hk_gate.sv ***
// one-stage register between the housekeeping packetiser and the outbound queue
// assumes the packetiser marks packet starts; a drop decision holds for a whole packet
`timescale 1ns/10ps
module hkd_hk_gate (
    input wire logic core_clk, // clock
    input wire logic rst_n, // async reset
    input wire logic fwd_en, // forwarding enabled
    input wire logic [7:0] hk_data, // packet byte in
    input wire logic hk_sop, // first byte of packet
    input wire logic hk_eop, // last byte of packet
    input wire logic hk_valid, // byte present
    output logic hk_ready, // byte taken
    output logic [7:0] ob_data, // byte to outbound queue
    output logic ob_sop, // first byte out
    output logic ob_eop, // last byte out
    output logic ob_valid, // byte out present
    input wire logic ob_ready, // outbound queue takes byte
    output logic hk_dropped // pulse: a packet was discarded
);
    logic [7:0] data_q, data_d;
    logic sop_q, sop_d, eop_q, eop_d, valid_q, valid_d;
    logic drop_q, drop_d;
    logic dropped_q, dropped_d;
    logic take, drop_now;

    // decision latched at packet start so a packet is never cut in half
    assign drop_now = hk_sop ? !fwd_en : drop_q;
    // dropped bytes are always accepted, so the packetiser never stalls on them
    assign hk_ready = drop_now || !valid_q || ob_ready;
    assign take = hk_valid && hk_ready;

    always_comb begin
        data_d = data_q;
        sop_d = sop_q;
        eop_d = eop_q;
        valid_d = valid_q && !ob_ready;
        drop_d = drop_q;
        dropped_d = 1'b0;
        if (take) begin
            drop_d = drop_now;
            if (drop_now) begin
                dropped_d = hk_eop;
            end else begin
                data_d = hk_data;
                sop_d = hk_sop;
                eop_d = hk_eop;
                valid_d = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            data_q <= 8'h00;
            sop_q <= 1'b0;
            eop_q <= 1'b0;
            valid_q <= 1'b0;
            drop_q <= 1'b0;
            dropped_q <= 1'b0;
        end else begin
            data_q <= data_d;
            sop_q <= sop_d;
            eop_q <= eop_d;
            valid_q <= valid_d;
            drop_q <= drop_d;
            dropped_q <= dropped_d;
        end
    end

    assign ob_data = data_q;
    assign ob_sop = sop_q;
    assign ob_eop = eop_q;
    assign ob_valid = valid_q;
    assign hk_dropped = dropped_q;
endmodule : hkd_hk_gate

// *** hdl/hkd_decoder.sv ***
// housekeeping forwarding command decoder: checks enable/disable commands,
// keeps the forwarding state, gates finished housekeeping packets, paces collection
// assumes the command stream is produced on core_clk, one byte per valid, always taken
//
// Summary of operation
// - fixed identifier, category, version, flags checked
// - nonzero source prefix rejected as foreign
// - length field seven and size checked
// - service version zero, checksum flag set
// - acknowledge field requests acceptance report
// - service type byte is housekeeping reporting
// - subtype selects enable or disable, then zero pad
// - application data: pad parameter one first
// - report selector must equal one
// - accepted disable stops housekeeping forwarding
// - collection and packetising continue while disabled
// - finished packets discarded while disabled
// - disable leaves collection activity untouched
// - accepted enable restores forwarding
// - collection recurs every 11.3 s unless skipped
`timescale 1ns/10ps
module hkd_decoder #(
    parameter int unsigned PERIOD_CYC = hkd_pkg::HK_PERIOD_CYC // collection period in cycles
) (
    input wire logic core_clk, // clock, 125 MHz
    input wire logic rst_n, // async reset, active low
    input wire logic [7:0] tc_data, // command byte
    input wire logic tc_valid, // command byte present
    input wire logic tc_sop, // first byte of command
    input wire logic tc_eop, // last byte of command
    output logic tc_accept, // pulse: command accepted
    output logic tc_reject, // pulse: command ignored
    output hkd_pkg::hkd_reason_t tc_reason, // why the last command was ignored
    output logic [10:0] tc_seq, // counter of last accepted command
    output logic fwd_en, // housekeeping forwarding state
    input wire logic cycle_skip, // collection cycle skip in force
    output logic hk_collect, // pulse: start a collection cycle
    input wire logic [7:0] hk_data, // packet byte from packetiser
    input wire logic hk_sop, // first byte of packet
    input wire logic hk_eop, // last byte of packet
    input wire logic hk_valid, // packet byte present
    output logic hk_ready, // packet byte taken
    output logic [7:0] ob_data, // byte to outbound queue
    output logic ob_sop, // first byte out
    output logic ob_eop, // last byte out
    output logic ob_valid, // byte out present
    input wire logic ob_ready, // outbound queue ready
    output logic hk_dropped // pulse: packet discarded
);
    import hkd_pkg::*;

    typedef enum logic [1:0] {
        HKD_ST_IDLE = 2'b00,
        HKD_ST_BODY = 2'b01,
        HKD_ST_CHECK = 2'b10
    } hkd_state_t;

    hkd_state_t state_q, state_d;
    logic [3:0] idx_q, idx_d;
    logic field_ok_q, field_ok_d;
    logic foreign_q, foreign_d;
    logic len_ok_q, len_ok_d;
    logic enable_q, enable_d;
    logic [10:0] seq_cur_q, seq_cur_d;
    logic [10:0] seq_q, seq_d;
    logic fwd_q, fwd_d;
    logic accept_q, accept_d;
    logic reject_q, reject_d;
    hkd_reason_t reason_q, reason_d;
    logic [3:0] pos;
    logic byte_take;

    hkd_crc_if crc_bus ();

    // byte position of the incoming byte; a start byte is always position zero
    assign byte_take = tc_valid && (tc_sop || state_q == HKD_ST_BODY);
    assign pos = tc_sop ? 4'h0 : idx_q;

    // checks one byte of the fixed layout; check word positions pass, positions past POS_LAST fail
    function automatic logic field_match(input logic [3:0] p, input logic [7:0] b);
        logic r;
        r = 1'b0;
        unique case (p)
            POS_ID_HI: r = (b == {VERSION_VAL, TYPE_VAL, DFH_VAL, APID_VAL[6:4]});
            POS_ID_LO: r = (b == {APID_VAL[3:0], CATEGORY_VAL});
            // flags here, source prefix judged apart
            POS_SEQ_HI: r = (b[7:6] == SEQ_FLAGS_VAL);
            POS_SEQ_LO: r = 1'b1;
            POS_LEN_HI: r = (b == LENGTH_VAL[15:8]);
            POS_LEN_LO: r = (b == LENGTH_VAL[7:0]);
            POS_SVC_HDR: r = (b == {SVC_VERSION_VAL, CHECKSUM_FLAG_VAL, ACK_VAL});
            POS_SVC_TYPE: r = (b == SVC_TYPE_VAL);
            POS_SUBTYPE: r = (b == SUB_DISABLE_VAL) || (b == SUB_ENABLE_VAL);
            POS_PAD: r = (b == PAD_VAL);
            POS_PAD_PARAM: r = (b == PAD_PARAM_VAL);
            POS_SELECTOR: r = (b == SELECTOR_VAL);
            default: r = (p <= POS_LAST);
        endcase
        return r;
    endfunction : field_match

    always_comb begin
        state_d = state_q;
        idx_d = idx_q;
        field_ok_d = field_ok_q;
        foreign_d = foreign_q;
        len_ok_d = len_ok_q;
        enable_d = enable_q;
        seq_cur_d = seq_cur_q;
        seq_d = seq_q;
        fwd_d = fwd_q;
        accept_d = 1'b0;
        reject_d = 1'b0;
        reason_d = reason_q;
        if (state_q == HKD_ST_CHECK) begin
            state_d = HKD_ST_IDLE;
            if (!len_ok_q) begin
                reject_d = 1'b1;
                reason_d = HKD_RSN_LENGTH;
            end else if (foreign_q) begin
                reject_d = 1'b1;
                reason_d = HKD_RSN_FOREIGN;
            end else if (!field_ok_q) begin
                reject_d = 1'b1;
                reason_d = HKD_RSN_FIELD;
            end else if (crc_bus.crc != CRC_RESIDUE) begin
                reject_d = 1'b1;
                reason_d = HKD_RSN_CRC;
            end else begin
                accept_d = 1'b1;
                reason_d = HKD_RSN_NONE;
                seq_d = seq_cur_q;
                fwd_d = enable_q;
            end
        end
        // a new start byte aborts any packet in progress
        if (byte_take) begin
            idx_d = (pos == 4'hf) ? pos : pos + 4'h1;
            if (tc_sop) begin
                field_ok_d = field_match(pos, tc_data);
                foreign_d = 1'b0;
            end else begin
                field_ok_d = field_ok_q && field_match(pos, tc_data);
            end
            if (pos == POS_SEQ_HI) begin
                foreign_d = (tc_data[5:3] != SOURCE_GROUND);
                seq_cur_d = {tc_data[2:0], seq_cur_q[7:0]};
            end
            if (pos == POS_SEQ_LO) begin
                seq_cur_d = {seq_cur_q[10:8], tc_data};
            end
            if (pos == POS_SUBTYPE) begin
                enable_d = (tc_data == SUB_ENABLE_VAL);
            end
            if (tc_eop) begin
                len_ok_d = (pos == POS_LAST);
                state_d = HKD_ST_CHECK;
            end else begin
                state_d = HKD_ST_BODY;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= HKD_ST_IDLE;
            idx_q <= 4'h0;
            field_ok_q <= 1'b0;
            foreign_q <= 1'b0;
            len_ok_q <= 1'b0;
            enable_q <= 1'b0;
            seq_cur_q <= 11'h000;
            seq_q <= 11'h000;
            fwd_q <= FWD_EN_RST;
            accept_q <= 1'b0;
            reject_q <= 1'b0;
            reason_q <= HKD_RSN_NONE;
        end else begin
            state_q <= state_d;
            idx_q <= idx_d;
            field_ok_q <= field_ok_d;
            foreign_q <= foreign_d;
            len_ok_q <= len_ok_d;
            enable_q <= enable_d;
            seq_cur_q <= seq_cur_d;
            seq_q <= seq_d;
            fwd_q <= fwd_d;
            accept_q <= accept_d;
            reject_q <= reject_d;
            reason_q <= reason_d;
        end
    end

    // the crc runs over every byte including the error control word itself
    assign crc_bus.clear = tc_sop;
    assign crc_bus.valid = byte_take;
    assign crc_bus.data = tc_data;

    hkd_crc16 u_crc (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .crc_bus(crc_bus)
    );

    // collection pacing: independent of the forwarding state on purpose
    logic [31:0] tick_cnt_q, tick_cnt_d;
    logic collect_q, collect_d;

    always_comb begin
        tick_cnt_d = tick_cnt_q;
        collect_d = 1'b0;
        if (tick_cnt_q >= PERIOD_CYC - 1) begin
            tick_cnt_d = 32'h0000_0000;
            collect_d = !cycle_skip;
        end else begin
            tick_cnt_d = tick_cnt_q + 32'h0000_0001;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_q <= 32'h0000_0000;
            collect_q <= 1'b0;
        end else begin
            tick_cnt_q <= tick_cnt_d;
            collect_q <= collect_d;
        end
    end

    hkd_hk_gate u_gate (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .fwd_en(fwd_q),
        .hk_data(hk_data),
        .hk_sop(hk_sop),
        .hk_eop(hk_eop),
        .hk_valid(hk_valid),
        .hk_ready(hk_ready),
        .ob_data(ob_data),
        .ob_sop(ob_sop),
        .ob_eop(ob_eop),
        .ob_valid(ob_valid),
        .ob_ready(ob_ready),
        .hk_dropped(hk_dropped)
    );

    assign tc_accept = accept_q;
    assign tc_reject = reject_q;
    assign tc_reason = reason_q;
    assign tc_seq = seq_q;
    assign fwd_en = fwd_q;
    assign hk_collect = collect_q;
endmodule : hkd_decoder

// *** verification/hkd_decoder_chk.sv ***
// port-level assertions for the housekeeping forwarding command decoder
// assumes one clock domain; attached to every decoder by the bind at the foot
`timescale 1ns/10ps
module hkd_decoder_chk #(
    parameter int unsigned PERIOD_CYC = 20 // collection period in cycles
) (
    input wire logic core_clk, // clock
    input wire logic rst_n, // async reset
    input wire logic [7:0] tc_data, // command byte
    input wire logic tc_valid, // byte present
    input wire logic tc_sop, // first byte
    input wire logic tc_eop, // last byte
    input wire logic tc_accept, // accepted pulse
    input wire logic tc_reject, // ignored pulse
    input wire hkd_pkg::hkd_reason_t tc_reason, // reject reason
    input wire logic [10:0] tc_seq, // last counter
    input wire logic fwd_en, // forwarding state
    input wire logic cycle_skip, // skip in force
    input wire logic hk_collect, // collection pulse
    input wire logic [7:0] hk_data, // packet byte
    input wire logic hk_sop, // packet start
    input wire logic hk_eop, // packet end
    input wire logic hk_valid, // packet byte present
    input wire logic hk_ready, // packet byte taken
    input wire logic [7:0] ob_data, // outbound byte
    input wire logic ob_sop, // outbound start
    input wire logic ob_eop, // outbound end
    input wire logic ob_valid, // outbound present
    input wire logic ob_ready, // outbound taken
    input wire logic hk_dropped // discard pulse
);
    import hkd_pkg::*;
    logic take, drop_now, drop_q, drop_d, seen_q, seen_d;
    logic [31:0] gap_q, gap_d;
    always_comb begin
        take = hk_valid && hk_ready;
        drop_now = hk_sop ? !fwd_en : drop_q;
        drop_d = take ? drop_now : drop_q;
        seen_d = seen_q || hk_collect;
        gap_d = hk_collect ? 32'h0 : gap_q + 32'h1;
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            drop_q <= 1'b0;
            seen_q <= 1'b0;
            gap_q <= 32'h0;
        end else begin
            drop_q <= drop_d;
            seen_q <= seen_d;
            gap_q <= gap_d;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    property p_pulse; (tc_accept || tc_reject) |-> !(tc_accept && tc_reject) ##1 !tc_accept; endproperty
    a_pulse: assert property (p_pulse) else $error("answer pulse malformed");
    property p_late; (tc_accept || tc_reject) |-> $past(tc_valid && tc_eop, 2); endproperty
    a_late: assert property (p_late) else $error("answer not two edges after last byte");
    property p_why; (tc_accept || tc_reject) |-> (tc_reason == HKD_RSN_NONE) == tc_accept; endproperty
    a_why: assert property (p_why) else $error("reason disagrees with answer");
    property p_state; $changed(fwd_en) |-> tc_accept; endproperty
    a_state: assert property (p_state) else $error("forwarding changed without command");
    property p_ready; (!ob_valid || ob_ready) |-> hk_ready; endproperty
    a_ready: assert property (p_ready) else $error("packetiser stalled needlessly");
    property p_hold; ob_valid && !ob_ready |=> ob_valid && $stable(ob_data) && $stable(ob_eop); endproperty
    a_hold: assert property (p_hold) else $error("outbound byte lost under stall");
    property p_fwd; take && !drop_now |=> ob_valid && ob_data == $past(hk_data)
        && ob_sop == $past(hk_sop) && ob_eop == $past(hk_eop); endproperty
    a_fwd: assert property (p_fwd) else $error("forwarded byte wrong");
    property p_drop; take && drop_now |=> !ob_valid
        || ($past(ob_valid && !ob_ready) && $stable(ob_data)); endproperty
    a_drop: assert property (p_drop) else $error("discarded byte reached outbound");
    property p_gone; hk_dropped == $past(take && drop_now && hk_eop); endproperty
    a_gone: assert property (p_gone) else $error("discard pulse misplaced");
    property p_period; hk_collect && seen_q |-> (gap_q + 32'h1) % PERIOD_CYC == 0; endproperty
    a_period: assert property (p_period) else $error("collection period wrong");
    property p_skip; hk_collect |-> !$past(cycle_skip); endproperty
    a_skip: assert property (p_skip) else $error("collection despite skip");
endmodule : hkd_decoder_chk

bind hkd_decoder hkd_decoder_chk #(.PERIOD_CYC(PERIOD_CYC)) i_hkd_decoder_chk (.core_clk, .rst_n,
    .tc_data, .tc_valid, .tc_sop, .tc_eop, .tc_accept, .tc_reject, .tc_reason, .tc_seq, .fwd_en,
    .cycle_skip, .hk_collect, .hk_data, .hk_sop, .hk_eop, .hk_valid, .hk_ready, .ob_data,
    .ob_sop, .ob_eop, .ob_valid, .ob_ready, .hk_dropped);

// *** verification/hkd_cdh_model.sv ***
// command source standing in for the spacecraft command handling side
// assumes the bench calls send and drives no tc_* signal itself
`timescale 1ns/10ps
module hkd_cdh_model (
    input wire logic core_clk, // clock
    output logic [7:0] tc_data, // command byte
    output logic tc_valid, // byte present
    output logic tc_sop, // first byte
    output logic tc_eop // last byte
);
    logic [10:0] seq_q = 11'h0;
    initial begin
        tc_data = 8'h00;
        tc_valid = 1'b0;
        tc_sop = 1'b0;
        tc_eop = 1'b0;
    end
    // released line shows a changing pattern, not the last byte
    task automatic idle;
        @(posedge core_clk);
        #1;
        tc_valid = 1'b0;
        tc_sop = 1'b0;
        tc_eop = 1'b0;
        tc_data = ~tc_data;
    endtask : idle
    // flip corrupts byte pos: before the check word for pos < 12, after it otherwise
    task automatic send(input logic [7:0] sub, input int pos, input logic [7:0] flip,
                        input int n, input int gap);
        logic [7:0] b [14];
        logic [15:0] c;
        int i;
        int j;
        b = '{8'h1c, 8'h7c, {5'h18, seq_q[10:8]}, seq_q[7:0], 8'h00, 8'h07, 8'h11, 8'hc0,
              sub, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00};
        if (pos < 12) b[pos] = b[pos] ^ flip;
        c = 16'hffff;
        for (i = 0; i < 12; i++) begin
            for (j = 7; j >= 0; j--) c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i][j]) ? 16'h1021 : 16'h0);
        end
        b[12] = c[15:8];
        b[13] = c[7:0];
        if (pos >= 12) b[pos] = b[pos] ^ flip;
        for (i = 0; i < n; i++) begin
            if (i > 0) repeat (gap) idle();
            @(posedge core_clk);
            #1;
            tc_data = b[i % 14];
            tc_valid = 1'b1;
            tc_sop = (i == 0);
            tc_eop = (i == n - 1);
        end
        idle();
        seq_q = seq_q + 11'h1;
    endtask : send
endmodule : hkd_cdh_model

// *** verification/hkd_decoder_test.sv ***
// self-checking bench for the housekeeping forwarding command decoder
// assumes the command model drives tc_*; the bench plays packetiser and queue
`timescale 1ns/10ps
module hkd_decoder_test;
    import hkd_pkg::*;
    localparam int unsigned PER = 20;
    logic core_clk, rst_n, cycle_skip, hk_sop, hk_eop, hk_valid, ob_ready, stall, took_q;
    logic tc_valid, tc_sop, tc_eop, tc_accept, tc_reject, fwd_en, hk_collect;
    logic hk_ready, ob_sop, ob_eop, ob_valid, hk_dropped;
    logic [7:0] hk_data, tc_data, ob_data;
    logic [10:0] tc_seq, last_seq;
    hkd_reason_t tc_reason;
    int n_mismatch = 0, n_tests = 0, n_coll = 0, n_drop = 0, n_sent = 0;
    logic [7:0] rx[$];
    hkd_cdh_model i_hkd_cdh_model (.core_clk, .tc_data, .tc_valid, .tc_sop, .tc_eop);
    hkd_decoder #(.PERIOD_CYC(PER)) i_hkd_decoder (.core_clk, .rst_n, .tc_data, .tc_valid,
        .tc_sop, .tc_eop, .tc_accept, .tc_reject, .tc_reason, .tc_seq, .fwd_en, .cycle_skip,
        .hk_collect, .hk_data, .hk_sop, .hk_eop, .hk_valid, .hk_ready, .ob_data, .ob_sop,
        .ob_eop, .ob_valid, .ob_ready, .hk_dropped);
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    // stall toggles the queue's ready so every held byte is seen under back-pressure
    always @(posedge core_clk) begin
        took_q <= hk_valid && hk_ready;
        if (ob_valid === 1'b1 && ob_ready === 1'b1) rx.push_back(ob_data);
        if (hk_dropped === 1'b1) n_drop++;
        if (hk_collect === 1'b1) n_coll++;
        ob_ready <= #1 stall ? !ob_ready : 1'b1;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : wrap_up
    task automatic cmd(input logic [7:0] sub, input int pos, input logic [7:0] flip, input int n,
                       input int gap, input logic acc, input logic [2:0] why);
        int k;
        last_seq = 11'(n_sent);
        n_sent++;
        i_hkd_cdh_model.send(sub, pos, flip, n, gap);
        for (k = 0; k < 8; k++) begin
            if (tc_accept === 1'b1 || tc_reject === 1'b1) break;
            @(posedge core_clk);
            #1;
        end
        if (k == 8) begin
            n_mismatch++;
            wrap_up();
        end
        check(tc_accept, acc);
        check(tc_reason, why);
    endtask : cmd
    task automatic hk_pkt(input logic fwd);
        int i;
        int k;
        int d0;
        rx.delete();
        d0 = n_drop;
        stall = 1'b1;
        for (i = 0; i < 5; i++) begin
            hk_data = 8'ha0 + 8'(i);
            hk_sop = (i == 0);
            hk_eop = (i == 4);
            hk_valid = 1'b1;
            for (k = 0; k < 9; k++) begin
                @(posedge core_clk);
                #1;
                if (took_q === 1'b1) break;
            end
            if (k == 9) begin
                n_mismatch++;
                wrap_up();
            end
        end
        hk_valid = 1'b0;
        hk_data = 8'h5f;
        stall = 1'b0;
        repeat (6) @(posedge core_clk);
        #1;
        check(16'(rx.size()), fwd ? 16'h5 : 16'h0);
        check(16'(n_drop - d0), fwd ? 16'h0 : 16'h1);
        for (i = 0; i < rx.size(); i++) check(rx[i], 8'ha0 + 8'(i));
    endtask : hk_pkt
    task automatic t_reset;
        check(fwd_en, 1'b1);
        check(tc_seq, 11'h0);
        check(ob_valid, 1'b0);
        hk_pkt(1'b1);
    endtask : t_reset
    task automatic t_disable;
        cmd(8'h06, 0, 8'h00, 14, 0, 1'b1, HKD_RSN_NONE);
        check(fwd_en, 1'b0);
        check(tc_seq, last_seq);
        hk_pkt(1'b0);
        n_coll = 0;
        repeat (3 * PER) @(posedge core_clk);
        #1;
        check(16'(n_coll), 16'h3);
    endtask : t_disable
    // each entry: byte position, bit flip, byte count, expected reason
    task automatic t_bad;
        logic [31:0] bad_v [15] = '{32'h00010e01, 32'h01010e01, 32'h02400e01, 32'h02080e02,
            32'h06800e01, 32'h06100e01, 32'h06020e01, 32'h07010e01, 32'h080f0e01, 32'h09010e01,
            32'h0a020e01, 32'h0b020e01, 32'h0c010e04, 32'h00000d03, 32'h00000f03};
        int i;
        for (i = 0; i < 15; i++) begin
            cmd(8'h05, int'(bad_v[i][31:24]), bad_v[i][23:16], int'(bad_v[i][15:8]), 0, 1'b0,
                bad_v[i][2:0]);
            check(fwd_en, 1'b0);
        end
    endtask : t_bad
    task automatic t_enable;
        cmd(8'h05, 0, 8'h00, 14, 1, 1'b1, HKD_RSN_NONE);
        check(fwd_en, 1'b1);
        check(tc_seq, last_seq);
        hk_pkt(1'b1);
    endtask : t_enable
    task automatic t_skip;
        cycle_skip = 1'b1;
        repeat (2) @(posedge core_clk);
        n_coll = 0;
        repeat (3 * PER) @(posedge core_clk);
        #1;
        check(16'(n_coll), 16'h0);
        cycle_skip = 1'b0;
    endtask : t_skip
    task automatic t_rst2;
        cmd(8'h06, 0, 8'h00, 14, 0, 1'b1, HKD_RSN_NONE);
        rst_n = 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        rst_n = 1'b1;
        check(fwd_en, 1'b1);
        check(tc_seq, 11'h0);
        hk_pkt(1'b1);
    endtask : t_rst2
    initial begin
        rst_n = 1'b0;
        cycle_skip = 1'b0;
        hk_data = 8'h00;
        hk_sop = 1'b0;
        hk_eop = 1'b0;
        hk_valid = 1'b0;
        ob_ready = 1'b1;
        stall = 1'b0;
        repeat (20) @(posedge core_clk);
        #1;
        rst_n = 1'b1;
        t_reset();
        t_disable();
        t_bad();
        t_enable();
        t_skip();
        t_rst2();
        wrap_up();
    end
endmodule : hkd_decoder_test
